/* File: design/rxs_top.sv */
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module rxs_top import rxs_pkg::*; #(
  parameter int unsigned HS_TIMEOUT_CYC = HS_TIMEOUT_US * (CLK_HZ / US_HZ),
  parameter logic [31:0] IDENTIFY_REQUEST_COMMAND       = 32'h0000_5A5A  // Arbitrary value
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic        i_dsr,
  input  wire logic        i_cts,
  input  wire logic        i_cd,
  output logic             o_dtr,
  output logic             o_rts,
  input  wire logic        i_cmd_valid,
  output logic             o_cmd_ready,
  input  wire rxs_cmd_t    i_cmd,
  output logic             o_rsp_valid,
  output rxs_rsp_t         o_rsp,
  output logic             o_word_strobe
);

  localparam int unsigned HS_W = $clog2(HS_TIMEOUT_CYC + 1);
  localparam logic [HS_W-1:0] HS_LAST = HS_W'(HS_TIMEOUT_CYC - 1);

  typedef struct packed {
    rxs_state_t  fsm;
    logic        dtr;
    logic        rts;
    logic        synced;
    logic        menus_reset;
    rxs_err_t    err;
    logic [15:0] baud_cnt;
    logic        tick;
    logic [HS_W-1:0] hs_cnt;
    logic [7:0]  xfer_cnt;
    logic [7:0]  slave_addr;
    logic [7:0]  first_blk;
    logic [7:0]  blk_count;
    logic [7:0]  capacity;
    logic [31:0] tmrcnt;
    logic [2:0]  baud_sel;
    logic        exec_req;
    logic        exit_req;
    logic        hang_req;
    logic        cmd_ready;
    logic        rsp_valid;
    rxs_rsp_t    rsp;
    logic        word_strobe;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rxs_st_t;

  rxs_st_t st_r;
  rxs_st_t st_nxt;

  // Byte-lane merge of a write
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic take;
  logic hit;
  logic third_app;
  assign take      = i_cmd_valid && st_r.cmd_ready;
  assign hit       = !i_cmd.third_party || (i_cmd.addr == st_r.slave_addr)
                     || (i_cmd.op == OP_ADDR_REQ);
  assign third_app = i_cmd.third_party && (i_cmd.op == OP_UPL_APPL || i_cmd.op == OP_DNL_APPL);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [31:0] bufw;
    logic [31:0] ctlw;
    rxs_err_t    e;
    logic        go;
    logic [7:0]  len;
    st_nxt = st_r;
    bufw = '0;
    ctlw = '0;
    e = ERR_NONE;
    go = 1'b0;
    len = 8'h00;
    st_nxt.exec_req = 1'b0;
    st_nxt.exit_req = 1'b0;
    st_nxt.hang_req = 1'b0;
    st_nxt.rsp_valid = 1'b0;
    st_nxt.word_strobe = 1'b0;
    st_nxt.tick = 1'b0;

    // Bit-rate divider
    if (st_r.baud_cnt >= rxs_baud_div(st_r.baud_sel) - 16'h0001) begin
      st_nxt.baud_cnt = 16'h0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.baud_cnt = st_r.baud_cnt + 16'h0001;
    end

    // AXI4-Lite write
    if (i_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = i_awaddr;
    end
    if (i_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = i_wdata;
      st_nxt.wstrb = i_wstrb;
    end
    if (st_r.bvalid && i_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      ctlw = wmerge({25'h0, st_r.baud_sel, 4'h0}, st_r.wdata, st_r.wstrb);
      bufw = wmerge({8'h00, st_r.capacity, st_r.blk_count, st_r.first_blk},
                    st_r.wdata, st_r.wstrb);
      unique case (st_r.aw_addr)
        OFF_CTRL: begin
          st_nxt.baud_sel = ctlw[CTRL_BAUD_LSB +: 3];
          st_nxt.exec_req = st_r.wstrb[0] && st_r.wdata[CTRL_EXEC];
          st_nxt.exit_req = st_r.wstrb[0] && st_r.wdata[CTRL_EXIT];
          st_nxt.hang_req = st_r.wstrb[0] && st_r.wdata[CTRL_HANG];
        end
        OFF_ADDR: st_nxt.slave_addr = st_r.wstrb[0] ? st_r.wdata[7:0] : st_r.slave_addr;
        OFF_BUF: begin
          st_nxt.first_blk = bufw[7:0];
          st_nxt.blk_count = bufw[15:8];
          st_nxt.capacity = bufw[23:16];
        end
        OFF_TMR: st_nxt.tmrcnt = wmerge(st_r.tmrcnt, st_r.wdata, st_r.wstrb);
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end

    // AXI4-Lite read
    if (st_r.rvalid && i_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (i_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      unique case (i_araddr)
        OFF_CTRL: st_nxt.rdata = {25'h0, st_r.baud_sel, 4'h0};
        OFF_ADDR: st_nxt.rdata = {24'h0, st_r.slave_addr};
        OFF_BUF:  st_nxt.rdata = {8'h00, st_r.capacity, st_r.blk_count, st_r.first_blk};
        OFF_TMR:  st_nxt.rdata = st_r.tmrcnt;
        OFF_STAT: st_nxt.rdata = {20'h0, st_r.menus_reset, st_r.synced, st_r.rts, st_r.dtr,
                                  3'h0, st_r.fsm};
        OFF_ERR:  st_nxt.rdata = {28'h0, st_r.err};
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Modem handshake and command interpreter
    if (st_r.hang_req) begin
      st_nxt.fsm = ST_IDLE;
      st_nxt.dtr = 1'b0;
      st_nxt.rts = 1'b0;
      st_nxt.synced = 1'b0;
    end else if (st_r.exit_req && st_r.fsm == ST_XFER) begin
      st_nxt.fsm = ST_LINKED;
    end else begin
      unique case (st_r.fsm)
        ST_IDLE: begin
          if (st_r.exec_req) begin
            st_nxt.dtr = 1'b1;
            st_nxt.fsm = ST_WAIT_DSR;
          end
        end
        ST_WAIT_DSR: begin
          if (i_dsr) begin
            st_nxt.rts = 1'b1;
            st_nxt.hs_cnt = '0;
            st_nxt.fsm = ST_WAIT_CTS;
          end
        end
        ST_WAIT_CTS: begin
          st_nxt.hs_cnt = st_r.hs_cnt + HS_W'(1);
          if (i_cts && i_cd) begin
            st_nxt.synced = 1'b0;
            st_nxt.fsm = ST_LINKED;
          end else if (st_r.hs_cnt == HS_LAST) begin
            st_nxt.err = ERR_HS_FAIL;
            st_nxt.rts = 1'b0;
            st_nxt.dtr = 1'b0;
            st_nxt.fsm = ST_IDLE;
          end
        end
        ST_LINKED: begin
          if (!(i_dsr && i_cts && i_cd)) begin
            st_nxt.rts = 1'b0;
            st_nxt.synced = 1'b0;
            st_nxt.fsm = ST_WAIT_DSR;
          end else if (take && hit) begin
            st_nxt.rsp_valid = 1'b1;
            st_nxt.rsp = '{kind: RSP_DATA, err: ERR_NONE, data: 32'h0000_0000};
            len = i_cmd.length;
            if (i_cmd.op == OP_ADDR_REQ) begin
              if (i_cmd.third_party) begin
                st_nxt.rsp.data = {24'h0, st_r.slave_addr};
              end else begin
                e = ERR_INV_OP;
              end
            end else if (i_cmd.op == OP_IDENT) begin
              st_nxt.synced = 1'b1;
              st_nxt.rsp.data = IDENTIFY_REQUEST_COMMAND;
            end else if (!st_r.synced) begin
              e = ERR_NOT_SYNCED;
            end else if (i_cmd.op == OP_STATUS) begin
              st_nxt.rsp.data = {28'h0, st_r.err};
              st_nxt.err = ERR_NONE;
            end else if (i_cmd.op == OP_MODEL_ONLY) begin
              e = ERR_INV_OP;
            end else if (i_cmd.op == OP_UPL_TMRCNT) begin
              if (i_cmd.third_party) begin
                st_nxt.rsp.data = st_r.tmrcnt;
              end else begin
                e = ERR_INV_OP;
              end
            end else if (third_app) begin
              e = ERR_APPL_REFUSED;
            end else if (i_cmd.op == OP_DNL_DATA && i_cmd.length > st_r.capacity) begin
              e = ERR_BUF_SMALL;
            end else if (i_cmd.op == OP_UPL_DATA && st_r.blk_count == 8'h00) begin
              e = ERR_BUF_EMPTY;
            end else if (i_cmd.op == OP_UPL_DATA && i_cmd.start_blk != st_r.first_blk) begin
              e = ERR_START_FIRST;
            end else if (i_cmd.op == OP_UPL_DATA && i_cmd.end_blk < i_cmd.start_blk) begin
              e = ERR_NO_DATA;
            end else if (i_cmd.op == OP_DNL_MENUS && !i_cmd.menu_valid) begin
              e = ERR_CONV_RESET;
              st_nxt.menus_reset = 1'b1;
            end else if (i_cmd.op == OP_DNL_MENUS && !i_cmd.menu_usable) begin
              e = ERR_MENU_INCOMPAT;
            end else if (i_cmd.op == OP_DNL_MENUS && i_cmd.trig_missing) begin
              e = ERR_INV_MONSIM;
            end else begin
              go = 1'b1;
              if (i_cmd.op == OP_UPL_DATA) begin
                len = i_cmd.end_blk - i_cmd.start_blk + 8'h01;
              end
              if (i_cmd.op == OP_DNL_MENUS) begin
                st_nxt.menus_reset = 1'b0;
              end
            end
            if (e != ERR_NONE) begin
              st_nxt.err = e;
              st_nxt.rsp = '{kind: RSP_REJECT, err: e, data: 32'h0000_0000};
            end
            if (go) begin
              st_nxt.rsp_valid = 1'b0;
              st_nxt.xfer_cnt = (len == 8'h00) ? 8'h01 : len;
              st_nxt.fsm = ST_XFER;
            end
          end
        end
        ST_XFER: begin
          if (st_r.tick) begin
            st_nxt.word_strobe = 1'b1;
            st_nxt.xfer_cnt = st_r.xfer_cnt - 8'h01;
            if (st_r.xfer_cnt == 8'h01) begin
              st_nxt.rsp_valid = 1'b1;
              st_nxt.rsp = '{kind: RSP_OK, err: ERR_NONE, data: 32'h0000_0000};
              st_nxt.fsm = ST_LINKED;
            end
          end
        end
      endcase
    end

    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;
    st_nxt.cmd_ready = (st_nxt.fsm == ST_LINKED);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_r <= '0;
      st_r.fsm <= ST_IDLE;
      st_r.err <= ERR_NONE;
      st_r.baud_sel <= BAUD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_awready     = st_r.awready;
  assign o_wready      = st_r.wready;
  assign o_bvalid      = st_r.bvalid;
  assign o_bresp       = st_r.bresp;
  assign o_arready     = st_r.arready;
  assign o_rvalid      = st_r.rvalid;
  assign o_rdata       = st_r.rdata;
  assign o_rresp       = st_r.rresp;
  assign o_dtr         = st_r.dtr;
  assign o_rts         = st_r.rts;
  assign o_cmd_ready   = st_r.cmd_ready;
  assign o_rsp_valid   = st_r.rsp_valid;
  assign o_rsp         = st_r.rsp;
  assign o_word_strobe = st_r.word_strobe;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  logic acc;
  assign acc = take && hit && st_r.fsm == ST_LINKED && i_dsr && i_cts && i_cd;

  AST_HANG_DTR: assert property (st_r.hang_req |=> !o_dtr && st_r.fsm == ST_IDLE)
    else $error("DTR still high after hang-up");
  AST_DTR_RISE: assert property ($rose(o_dtr) |-> $past(st_r.exec_req))
    else $error("DTR rose without execute");
  AST_RTS_RISE: assert property ($rose(o_rts) |-> $past(i_dsr) && o_dtr)
    else $error("RTS rose before DSR");
  AST_LINK_UP: assert property ($rose(o_cmd_ready) |-> $past(i_cts && i_cd) && o_rts)
    else $error("Link up without CTS and CD");
  AST_ADDR_MISS: assert property (take && !hit |=> !o_rsp_valid)
    else $error("Answered a foreign address");
  AST_NOT_SYNCED: assert property (acc && !st_r.synced && i_cmd.op != OP_IDENT
    && i_cmd.op != OP_ADDR_REQ |=> o_rsp_valid && o_rsp.err == ERR_NOT_SYNCED)
    else $error("Transfer taken before identify");
  AST_APPL_REFUSE: assert property (acc && st_r.synced && third_app
    |=> o_rsp_valid && o_rsp.kind == RSP_REJECT && st_r.err == ERR_APPL_REFUSED)
    else $error("Program transfer not refused");
  AST_STATUS_CLR: assert property (acc && st_r.synced && i_cmd.op == OP_STATUS
    |=> o_rsp.data[3:0] == $past(st_r.err) && st_r.err == ERR_NONE)
    else $error("Status query did not report and clear");
  AST_HS_FAIL: assert property (st_r.fsm == ST_WAIT_CTS && !(i_cts && i_cd)
    && st_r.hs_cnt == HS_LAST |=> st_r.err == ERR_HS_FAIL && !o_rts)
    else $error("Handshake timeout not flagged");
  AST_BUF_SMALL: assert property (acc && st_r.synced && i_cmd.op == OP_DNL_DATA
    && i_cmd.length > st_r.capacity |=> st_r.err == ERR_BUF_SMALL)
    else $error("Oversized download not flagged");
  AST_EXIT_ABORT: assert property (st_r.exit_req && !st_r.hang_req && st_r.fsm == ST_XFER
    |=> st_r.fsm == ST_LINKED && !o_rsp_valid)
    else $error("Exit did not abort transfer");
  AST_MODEL_ONLY: assert property (acc && st_r.synced && i_cmd.op == OP_MODEL_ONLY
    |=> o_rsp.err == ERR_INV_OP)
    else $error("Model-only command not rejected");

  COV_LINK: cover property ($rose(o_cmd_ready));
  COV_IDENT: cover property (acc && i_cmd.op == OP_IDENT);
  COV_XFER_DONE: cover property (st_r.fsm == ST_XFER ##1 o_rsp_valid && o_rsp.kind == RSP_OK);
  COV_HS_FAIL: cover property (st_r.err == ERR_HS_FAIL);

endmodule

/* File: design/rxs_pkg.sv */
// What this block does
// - Answer every controller command except third-party ones other than address request for another address, move menus/data/programs
// - Keep transfer error, report on status query
// - Third-party controller: refuse program transfers
// - Third-party timer/counter upload returns timer state
// - Third-party commands other than address request act only on address match
// - Address request allowed from third-party controller only
// - Exit aborts; hang-up drops DTR until execute
// - Execute raises DTR, then wait for DSR
// - After DSR raise RTS, wait CTS and CD
// - Flag buffer-capacity error on oversized download
// - Reject upload not starting at first block
// - Flag empty block range and empty buffer
// - Invalid menus reset menus; flag unusable menus
// - Flag modem handshake failure on RTS/CTS timeout
// - Flag conditional lead test without trigger
// - Reject model-only commands as invalid operation
// - Refuse transfers until identify request synchronises link
// - Bit rate selectable from 9600 down to 200
package rxs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned HS_TIMEOUT_US = 1000;
  localparam int unsigned US_HZ         = 1_000_000;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_BUF  = 8'h08;
  localparam logic [7:0] OFF_TMR  = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_ERR  = 8'h14;
  localparam int unsigned CTRL_EXEC     = 0;
  localparam int unsigned CTRL_EXIT     = 1;
  localparam int unsigned CTRL_HANG     = 2;
  localparam int unsigned CTRL_BAUD_LSB = 4;
  localparam logic [2:0]  BAUD_RST      = 3'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ****************************************
  // Commands, errors, states
  // ****************************************
  typedef enum logic [3:0] {
    OP_UPL_MENUS = 4'h0, OP_UPL_DATA = 4'h1, OP_UPL_APPL = 4'h2, OP_STATUS = 4'h3,
    OP_IDENT     = 4'h4, OP_DNL_MENUS = 4'h5, OP_DNL_DATA = 4'h6, OP_DNL_APPL = 4'h7,
    OP_UPL_TMRCNT = 4'h8, OP_ADDR_REQ = 4'h9, OP_MODEL_ONLY = 4'hA
  } rxs_op_t;

  typedef enum logic [3:0] {
    ERR_NONE = 4'h0, ERR_BUF_SMALL = 4'h1, ERR_START_FIRST = 4'h2, ERR_NO_DATA = 4'h3,
    ERR_BUF_EMPTY = 4'h4, ERR_CONV_RESET = 4'h5, ERR_MENU_INCOMPAT = 4'h6,
    ERR_HS_FAIL = 4'h7, ERR_INV_MONSIM = 4'h8, ERR_INV_OP = 4'h9, ERR_NOT_SYNCED = 4'hA,
    ERR_APPL_REFUSED = 4'hB
  } rxs_err_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_WAIT_DSR = 5'h02, ST_WAIT_CTS = 5'h04, ST_LINKED = 5'h08,
    ST_XFER = 5'h10
  } rxs_state_t;

  typedef enum logic [1:0] {RSP_OK = 2'h0, RSP_REJECT = 2'h1, RSP_DATA = 2'h2} rxs_kind_t;

  typedef struct packed {
    rxs_op_t    op;
    logic       third_party;
    logic [7:0] addr;
    logic [7:0] start_blk;
    logic [7:0] end_blk;
    logic [7:0] length;
    logic       menu_valid;
    logic       menu_usable;
    logic       trig_missing;
  } rxs_cmd_t;

  typedef struct packed {
    rxs_kind_t   kind;
    rxs_err_t    err;
    logic [31:0] data;
  } rxs_rsp_t;

  // Bit-rate divisor for each selection
  function automatic logic [15:0] rxs_baud_div(input logic [2:0] sel);
    int unsigned rate;
    unique case (sel)
      3'h0: rate = 9600;
      3'h1: rate = 4800;
      3'h2: rate = 2400;
      3'h3: rate = 1200;
      3'h4: rate = 600;
      3'h5: rate = 300;
      default: rate = 200;
    endcase
    return 16'(CLK_HZ / rate);
  endfunction

endpackage

/* File: test/rxs_modem_model.sv */
`timescale 1ns/1ps
module rxs_modem_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_dly,
  input  wire logic       i_no_cts,
  input  wire logic       i_dtr,
  input  wire logic       i_rts,
  output logic            o_dsr,
  output logic            o_cts,
  output logic            o_cd
);
  logic [7:0] dsr_cnt_r;
  logic [7:0] cts_cnt_r;
  // ****************************************
  // Far-side modem: DSR follows DTR, CTS and CD follow RTS
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_dtr) dsr_cnt_r <= 8'h00;
    else if (~&dsr_cnt_r) dsr_cnt_r <= dsr_cnt_r + 8'h01;
    if (!i_rts) cts_cnt_r <= 8'h00;
    else if (~&cts_cnt_r) cts_cnt_r <= cts_cnt_r + 8'h01;
  end
  assign o_dsr = i_dtr && (dsr_cnt_r >= i_dly);
  assign o_cts = i_rts && !i_no_cts && (cts_cnt_r >= i_dly);
  assign o_cd  = o_cts;
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top import rxs_pkg::*;;
  localparam logic [31:0] SID  = 32'h0000_1234;  // Arbitrary value
  localparam logic [7:0]  ADR  = 8'h33;
  localparam logic [7:0]  Z    = 8'h00;
  localparam logic [2:0]  OK   = 3'h6;
  localparam logic        N    = 1'b0;
  localparam logic        Y    = 1'b1;
  localparam int          LIMIT = 60000;
  typedef struct {rxs_cmd_t c; logic r; rxs_rsp_t x; int n;} rxs_row_t;
  logic       i_clk = 1'b0, i_rst_b = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0;
  logic       i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0, i_cmd_valid = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, m_dly = 8'h06;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hF;
  logic       m_no_cts = 1'b0;
  rxs_cmd_t   i_cmd = '0;
  logic       o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cmd_ready;
  logic       o_rsp_valid, o_word_strobe, o_dtr, o_rts, i_dsr, i_cts, i_cd;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  rxs_rsp_t   o_rsp;
  rxs_row_t   rows[$];
  int         fails = 0, checked = 0, cyc = 0, last = 0, gap = 0, strb = 0;

  rxs_top #(.HS_TIMEOUT_CYC(20), .IDENTIFY_REQUEST_COMMAND(SID)) rxs_top_i (.*);
  rxs_modem_model rxs_modem_model_i (.i_clk(i_clk), .i_dly(m_dly), .i_no_cts(m_no_cts),
    .i_dtr(o_dtr), .i_rts(o_rts), .o_dsr(i_dsr), .o_cts(i_cts), .o_cd(i_cd));

  // ****************************************
  // Clock, strobe spacing, timeout
  // ****************************************
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_word_strobe === 1'b1) begin
      gap <= cyc - last;
      last <= cyc;
      strb <= strb + 1;
    end
    if (cyc == LIMIT) begin
      fails++;
      close_out();
    end
  end

  // ****************************************
  // Checks and bus tasks
  // ****************************************
  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rsp(input rxs_rsp_t got, input rxs_rsp_t exp);
    checked++;
    if (got.kind !== exp.kind || got.err !== exp.err ||
        (exp.kind == RSP_DATA && got.data !== exp.data)) begin
      fails++;
      $display("mismatch at %0t: response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_clk);
    i_awvalid <= 1'b1;
    i_awaddr <= a;
    i_wvalid <= 1'b1;
    i_wdata <= d;
    i_bready <= 1'b1;
    fork
      begin
        do @(posedge i_clk); while (o_awready !== 1'b1);
        i_awvalid <= 1'b0;
      end
      begin
        do @(posedge i_clk); while (o_wready !== 1'b1);
        i_wvalid <= 1'b0;
      end
    join
    do @(posedge i_clk); while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
    chk_val({30'h0, o_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m,
                    input logic [1:0] er);
    @(posedge i_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
    chk_val(o_rdata & m, ed);
    chk_val({30'h0, o_rresp}, {30'h0, er});
  endtask
  task automatic run(input rxs_cmd_t c, input int lim, output logic got);
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= c;
    do @(posedge i_clk); while (o_cmd_ready !== 1'b1);
    i_cmd_valid <= 1'b0;
    got = 1'b0;
    for (int n = 0; n < lim && !got; n++) begin
      @(posedge i_clk);
      got = (o_rsp_valid === 1'b1);
    end
  endtask
  task automatic do_row(input rxs_row_t w);
    logic got;
    int   s0;
    s0 = strb;
    run(w.c, w.r ? 20000 : 30, got);
    chk_val({31'h0, got}, {31'h0, w.r});
    if (w.r) chk_rsp(o_rsp, w.x);
    @(negedge i_clk);
    chk_val(strb - s0, w.n);
  endtask
  function automatic rxs_cmd_t mk(rxs_op_t op, logic tp, logic [7:0] a, s, e, l,
                                  logic [2:0] f);
    mk = '{op, tp, a, s, e, l, f[2], f[1], f[0]};
  endfunction
  task automatic add(rxs_cmd_t c, logic r, rxs_kind_t k, rxs_err_t e, logic [31:0] d,
                     int n);
    rows.push_back('{c, r, rxs_rsp_t'{k, e, d}, n});
  endtask
  task automatic link_up();
    axi_wr(OFF_CTRL, 32'h1, RESP_OKAY);
    repeat (3) @(posedge i_clk);
    chk_val({30'h0, o_dtr, o_rts}, 32'h2);
    do @(posedge i_clk); while (o_cmd_ready !== 1'b1);
    chk_val({30'h0, o_dtr, o_rts}, 32'h3);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic got;
    int   s0;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(OFF_STAT, 32'h1, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_ERR, 32'h0, 32'hF, RESP_OKAY);
    axi_wr(OFF_STAT, 32'h0, RESP_SLVERR);
    rd(8'h18, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_wr(OFF_ADDR, {24'h0, ADR}, RESP_OKAY);
    rd(OFF_ADDR, {24'h0, ADR}, 32'hFF, RESP_OKAY);
    axi_wr(OFF_BUF, 32'h0010_0405, RESP_OKAY);
    axi_wr(OFF_TMR, 32'hCAFE_0042, RESP_OKAY);
    link_up();
    add(mk(OP_UPL_MENUS, N, Z, Z, Z, Z, OK), Y, RSP_REJECT, ERR_NOT_SYNCED, 0, 0);
    add(mk(OP_IDENT, N, 8'h77, Z, Z, Z, OK), Y, RSP_DATA, ERR_NONE, SID, 0);
    add(mk(OP_ADDR_REQ, Y, Z, Z, Z, Z, OK), Y, RSP_DATA, ERR_NONE, 32'h33, 0);
    add(mk(OP_ADDR_REQ, N, Z, Z, Z, Z, OK), Y, RSP_REJECT, ERR_INV_OP, 0, 0);
    add(mk(OP_MODEL_ONLY, N, Z, Z, Z, Z, OK), Y, RSP_REJECT, ERR_INV_OP, 0, 0);
    add(mk(OP_UPL_TMRCNT, Y, ADR, Z, Z, Z, OK), Y, RSP_DATA, ERR_NONE, 32'hCAFE_0042, 0);
    add(mk(OP_UPL_TMRCNT, N, Z, Z, Z, Z, OK), Y, RSP_REJECT, ERR_INV_OP, 0, 0);
    add(mk(OP_UPL_APPL, Y, ADR, Z, Z, Z, OK), Y, RSP_REJECT, ERR_APPL_REFUSED, 0, 0);
    add(mk(OP_DNL_APPL, Y, ADR, Z, Z, Z, OK), Y, RSP_REJECT, ERR_APPL_REFUSED, 0, 0);
    add(mk(OP_UPL_MENUS, Y, 8'h34, Z, Z, Z, OK), N, RSP_OK, ERR_NONE, 0, 0);
    add(mk(OP_DNL_DATA, N, Z, Z, Z, 8'h11, OK), Y, RSP_REJECT, ERR_BUF_SMALL, 0, 0);
    add(mk(OP_UPL_DATA, N, Z, 8'h6, 8'h7, Z, OK), Y, RSP_REJECT, ERR_START_FIRST, 0, 0);
    add(mk(OP_UPL_DATA, N, Z, 8'h5, 8'h4, Z, OK), Y, RSP_REJECT, ERR_NO_DATA, 0, 0);
    add(mk(OP_DNL_MENUS, N, Z, Z, Z, Z, 3'h2), Y, RSP_REJECT, ERR_CONV_RESET, 0, 0);
    add(mk(OP_DNL_MENUS, N, Z, Z, Z, Z, 3'h4), Y, RSP_REJECT, ERR_MENU_INCOMPAT, 0, 0);
    add(mk(OP_DNL_MENUS, N, Z, Z, Z, Z, 3'h7), Y, RSP_REJECT, ERR_INV_MONSIM, 0, 0);
    add(mk(OP_STATUS, N, Z, Z, Z, Z, OK), Y, RSP_DATA, ERR_NONE, 32'h8, 0);
    add(mk(OP_STATUS, N, Z, Z, Z, Z, OK), Y, RSP_DATA, ERR_NONE, 32'h0, 0);
    add(mk(OP_UPL_DATA, N, Z, 8'h5, 8'h6, Z, OK), Y, RSP_OK, ERR_NONE, 0, 2);
    add(mk(OP_UPL_APPL, N, Z, Z, Z, 8'h1, OK), Y, RSP_OK, ERR_NONE, 0, 1);
    add(mk(OP_DNL_MENUS, N, Z, Z, Z, Z, OK), Y, RSP_OK, ERR_NONE, 0, 1);
    add(mk(OP_DNL_DATA, Y, ADR, Z, Z, 8'h10, OK), Y, RSP_OK, ERR_NONE, 0, 16);
    foreach (rows[i]) do_row(rows[i]);
    chk_val(gap, CLK_HZ / 9600);
    axi_wr(OFF_BUF, 32'h0010_0005, RESP_OKAY);
    do_row('{mk(OP_UPL_DATA, N, Z, 8'h5, 8'h5, Z, OK), Y,
             rxs_rsp_t'{RSP_REJECT, ERR_BUF_EMPTY, 0}, 0});
    rd(OFF_ERR, 32'h4, 32'hF, RESP_OKAY);
    fork
      run(mk(OP_DNL_DATA, N, Z, Z, Z, 8'h5, OK), 6000, got);
      begin
        s0 = strb;
        do @(posedge i_clk); while (strb == s0);
        axi_wr(OFF_CTRL, 32'h2, RESP_OKAY);
      end
    join
    chk_val({31'h0, got}, 32'h0);
    rd(OFF_STAT, 32'h8, 32'h1F, RESP_OKAY);
    axi_wr(OFF_CTRL, 32'h10, RESP_OKAY);
    axi_wr(OFF_BUF, 32'h0010_0405, RESP_OKAY);
    do_row('{mk(OP_UPL_DATA, N, Z, 8'h5, 8'h6, Z, OK), Y,
             rxs_rsp_t'{RSP_OK, ERR_NONE, 0}, 2});
    chk_val(gap, CLK_HZ / 4800);
    axi_wr(OFF_CTRL, 32'h4, RESP_OKAY);
    repeat (20) @(posedge i_clk);
    chk_val({30'h0, o_dtr, o_rts}, 32'h0);
    link_up();
    do_row('{mk(OP_UPL_MENUS, N, Z, Z, Z, Z, OK), Y,
             rxs_rsp_t'{RSP_REJECT, ERR_NOT_SYNCED, 0}, 0});
    axi_wr(OFF_CTRL, 32'h4, RESP_OKAY);
    m_no_cts <= 1'b1;
    m_dly <= 8'h00;
    axi_wr(OFF_CTRL, 32'h1, RESP_OKAY);
    repeat (40) @(posedge i_clk);
    chk_val({30'h0, o_dtr, o_rts}, 32'h0);
    rd(OFF_ERR, 32'h7, 32'hF, RESP_OKAY);
    rd(OFF_STAT, 32'h1, 32'h1F, RESP_OKAY);
    close_out();
  end
endmodule
